// >>> pkg/dcs_pkg.sv
// shared constants and types for the dual clock synthesiser control block
package dcs_pkg;

  // ==========================================================
  // programming word
  localparam int WORD_W = 22;
  localparam int IDX_W = 4;
  localparam int FB_W = 7;
  localparam int POST_W = 3;
  localparam int REFC_W = 7;
  localparam logic [7:0] FB_OFFSET = 8'h03;
  localparam logic [7:0] REFC_OFFSET = 8'h02;
  localparam logic [WORD_W-1:0] WORD_RST = 22'h000400;

  typedef struct packed {
    logic [IDX_W-1:0] range_idx;
    logic [FB_W-1:0] fb_cnt;
    logic rsv;
    logic [POST_W-1:0] post_sel;
    logic [REFC_W-1:0] ref_cnt;
  } dcs_word_s;

  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [11:0] CTRL_OFFS = 12'h000;
  localparam logic [11:0] STAT_OFFS = 12'h004;
  localparam logic [11:0] WORD_A_OFFS = 12'h008;
  localparam logic [11:0] WORD_B_OFFS = 12'h00C;
  localparam logic [15:0] QUIET_RST = 16'h0010;

  // status field positions
  localparam int ST_SETTLED_A = 0;
  localparam int ST_SETTLED_B = 1;
  localparam int ST_ON_SYN_A = 2;
  localparam int ST_ON_SYN_B = 3;
  localparam int ST_BUSY_A = 4;
  localparam int ST_BUSY_B = 5;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_MS = 10;
  localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
  localparam int BUDGET_W = 10;

  typedef struct packed {
    logic clk;
    logic oe;
  } dcs_pin_s;

endpackage

// >>> hdl/dcs_ser_rx.sv
// serial programming word receiver for one channel
`timescale 1ns/1ps
module dcs_ser_rx
  import dcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic [15:0] quiet_cycles,
  output logic word_load,
  output logic [WORD_W-1:0] word,
  output logic busy
);

  // ==========================================================
  // three-stage synchronisers
  logic [2:0] sck_q;
  logic [2:0] dat_q;
  logic sck_lvl_q;
  logic [WORD_W-1:0] shift_q;
  logic [15:0] quiet_q;
  logic busy_q;
  logic [WORD_W-1:0] word_q;
  logic load_q;
  wire sck_agree = sck_q[1] == sck_q[2];
  wire sck_rise = sck_agree && sck_q[2] && !sck_lvl_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_q <= 3'h0;
      dat_q <= 3'h0;
      sck_lvl_q <= 1'b0;
    end
    else
    begin
      sck_q <= {sck_q[1:0], serial_clk};
      dat_q <= {dat_q[1:0], serial_data};
      if (sck_agree)
        sck_lvl_q <= sck_q[2];
    end
  end

  // ==========================================================
  // shift in lsb first; older bits fall off so the last 22 stay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_q <= WORD_RST;
      quiet_q <= 16'h0000;
      busy_q <= 1'b0;
      word_q <= WORD_RST;
      load_q <= 1'b0;
    end
    else
    begin
      load_q <= 1'b0;
      if (sck_rise)
      begin
        shift_q <= {dat_q[2], shift_q[WORD_W-1:1]};
        quiet_q <= 16'h0000;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        // the word only commits once the serial clock has been quiet
        if (quiet_q >= quiet_cycles)
        begin
          busy_q <= 1'b0;
          word_q <= shift_q;
          load_q <= 1'b1;
        end
        else
          quiet_q <= quiet_q + 16'h0001;
      end
    end
  end

  assign word_load = load_q;
  assign word = word_q;
  assign busy = busy_q;

endmodule

// >>> hdl/dcs_clk_mux.sv
// glitch-free two-source clock selector
`timescale 1ns/1ps
module dcs_clk_mux
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic syn_clk,
  input wire logic ref_clk,
  input wire logic sel_syn,
  output logic clk_out,
  output logic on_syn
);

  // ==========================================================
  // source changes only while both inputs are low, so no runt pulse
  logic sel_q;
  logic out_q;
  wire both_low = !syn_clk && !ref_clk;
  wire sel_d = (both_low && sel_syn != sel_q) ? sel_syn : sel_q;
  wire out_d = sel_d ? syn_clk : ref_clk;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      sel_q <= sel_d;
      out_q <= out_d;
    end
  end

  assign clk_out = out_q;
  assign on_syn = sel_q;

endmodule

// >>> hdl/dcs_ctrl.sv
// dual channel clock synthesiser control: programming, synthesis model, muxing
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Summary of operation
// - bypass select high drives the output at the programmed frequency.
// - bypass select low routes the reference clock to the output.
// - while bypassed the output stays at reference despite retuning.
// - host lowers select first; switch to reference is glitch-free.
// - settling takes up to 10 ms after the last bit; host waits.
// - host raises select after settling; switch to synthesis is glitch-free.
// - channel A gives full, half and quarter rate outputs, aligned.
// - output disable low tri-states the channel output.
// - disable inputs default high, leaving the output enabled.
// - synthesised rate is two times reference times feedback over reference count.
// - reference is divided by the programmed reference count.
// - word fields msb down: range, feedback-3, reserved, post select, refcount-2.
// - one bit per serial clock rising edge, lsb first.
// - more than 22 edges keeps only the latest 22 bits.
// - post divider divides by two to the power of its field.
module dcs_ctrl
  import dcs_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clk_in,
  input wire logic serial_data,
  input wire logic chan_a_serial_clk,
  input wire logic chan_b_serial_clk,
  input wire logic chan_a_ref_bypass_sel,
  input wire logic chan_b_ref_bypass_sel,
  input wire logic chan_a_output_disable_n,
  input wire logic chan_b_output_disable_n,
  output logic chan_a_clk_out,
  output logic chan_a_clk_out_oe,
  output logic chan_a_clk_half,
  output logic chan_a_clk_half_oe,
  output logic chan_a_clk_quarter,
  output logic chan_a_clk_quarter_oe,
  output logic chan_b_clk_out,
  output logic chan_b_clk_out_oe,
  output logic ref_osc_buffered_out
);

  localparam int ST_W = $clog2(SETTLE_CYCLES + 1);

  // a zero settle count would leave the settled flag stuck high
  if (SETTLE_CYCLES < 1)
  begin : g_bad_settle
    $error("SETTLE_CYCLES must be at least one");
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] fb_of(input dcs_word_s w);
    fb_of = {1'b0, w.fb_cnt} + FB_OFFSET;
  endfunction

  function automatic logic [7:0] refc_of(input dcs_word_s w);
    refc_of = {1'b0, w.ref_cnt} + REFC_OFFSET;
  endfunction

  // ==========================================================
  // reference input synchroniser
  logic [2:0] ref_q;
  logic ref_lvl_q;
  wire ref_agree = ref_q[1] == ref_q[2];
  wire ref_rise = ref_agree && ref_q[2] && !ref_lvl_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_q <= 3'h0;
      ref_lvl_q <= 1'b0;
    end
    else
    begin
      ref_q <= {ref_q[1:0], ref_clk_in};
      if (ref_agree)
        ref_lvl_q <= ref_q[2];
    end
  end

  // ==========================================================
  // apb registers
  logic [15:0] quiet_q;
  logic [31:0] rdata_q;
  dcs_word_s word_v [2];
  logic [1:0] settled_v;
  logic [1:0] on_syn_v;
  logic [1:0] busy_v;
  logic [1:0] mux_out_v;
  logic [1:0] oe_v;

  wire apb_acc = psel && penable;
  wire hit_ctrl = paddr == CTRL_OFFS;
  wire hit_stat = paddr == STAT_OFFS;
  wire hit_wa = paddr == WORD_A_OFFS;
  wire hit_wb = paddr == WORD_B_OFFS;
  wire hit_any = hit_ctrl || hit_stat || hit_wa || hit_wb;
  wire [31:0] stat_word = {26'h0, busy_v[1], busy_v[0], on_syn_v[1], on_syn_v[0],
                           settled_v[1], settled_v[0]};
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, quiet_q} :
                       hit_stat ? stat_word :
                       hit_wa ? {10'h0, word_v[0]} :
                       hit_wb ? {10'h0, word_v[1]} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_q <= QUIET_RST;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      if (apb_acc && pwrite && hit_ctrl)
        quiet_q <= pwdata[15:0];
      if (psel && !penable && !pwrite)
        rdata_q <= rd_mux;
    end
  end

  assign pready = 1'b1;
  assign pslverr = apb_acc && !hit_any;
  assign prdata = rdata_q;

  // ==========================================================
  // per channel: receiver, synthesis model, post divider, mux
  wire [1:0] sck_pins = {chan_b_serial_clk, chan_a_serial_clk};
  wire [1:0] sel_pins = {chan_b_ref_bypass_sel, chan_a_ref_bypass_sel};
  wire [1:0] dis_pins = {chan_b_output_disable_n, chan_a_output_disable_n};

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    logic load;
    logic [WORD_W-1:0] rx_word;
    logic [2:0] sel_q;
    logic [2:0] dis_q;
    logic sel_lvl_q;
    logic dis_lvl_q;
    logic [7:0] rdiv_q;
    logic [BUDGET_W-1:0] budget_q;
    logic [6:0] post_q;
    logic syn_q;
    logic [ST_W-1:0] settle_q;

    dcs_ser_rx u_rx (
      .pclk(pclk),
      .presetn(presetn),
      .serial_clk(sck_pins[ch]),
      .serial_data(serial_data),
      .quiet_cycles(quiet_q),
      .word_load(load),
      .word(rx_word),
      .busy(busy_v[ch])
    );

    assign word_v[ch] = dcs_word_s'(rx_word);

    // divided reference: one compare tick every refcount reference edges
    wire [7:0] q_val = refc_of(word_v[ch]);
    wire cmp_tick = ref_rise && (rdiv_q >= q_val - 8'h01);
    // each compare tick grants 4*P vco half-periods: 2*ref_clk_in*P/Q
    wire [BUDGET_W-1:0] grant = cmp_tick ? {fb_of(word_v[ch]), 2'b00} : '0;
    wire spend = budget_q != '0;
    wire [BUDGET_W:0] budget_sum = {1'b0, budget_q} + {1'b0, grant} - {{BUDGET_W{1'b0}}, spend};
    // saturate rather than wrap, so an overfull budget never turns into a short burst
    wire [BUDGET_W-1:0] budget_d = budget_sum[BUDGET_W] ? '1 : budget_sum[BUDGET_W-1:0];
    // post divider toggles every 2^M vco toggles
    // counting toggles rather than periods keeps m = 0 and m > 0 on one path
    wire [6:0] post_lim = 7'((8'h01 << word_v[ch].post_sel) - 8'h01);
    wire post_wrap = spend && (post_q >= post_lim);

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        sel_q <= 3'h0;
        dis_q <= 3'h7;
        sel_lvl_q <= 1'b0;
        dis_lvl_q <= 1'b1;
      end
      else
      begin
        sel_q <= {sel_q[1:0], sel_pins[ch]};
        dis_q <= {dis_q[1:0], dis_pins[ch]};
        if (sel_q[1] == sel_q[2])
          sel_lvl_q <= sel_q[2];
        if (dis_q[1] == dis_q[2])
          dis_lvl_q <= dis_q[2];
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rdiv_q <= 8'h00;
        budget_q <= '0;
        post_q <= 7'h00;
        syn_q <= 1'b0;
      end
      else
      begin
        if (load)
          rdiv_q <= 8'h00;
        else if (cmp_tick)
          rdiv_q <= 8'h00;
        else if (ref_rise)
          rdiv_q <= rdiv_q + 8'h01;
        budget_q <= budget_d;
        if (load)
          post_q <= 7'h00;
        else if (post_wrap)
          post_q <= 7'h00;
        else if (spend)
          post_q <= post_q + 7'h01;
        if (post_wrap)
          syn_q <= !syn_q;
      end
    end

    // settle timer restarts on every committed word
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        settle_q <= ST_W'(SETTLE_CYCLES);
      else if (load)
        settle_q <= '0;
      else if (settle_q != ST_W'(SETTLE_CYCLES))
        settle_q <= settle_q + 1'b1;
    end

    assign settled_v[ch] = settle_q == ST_W'(SETTLE_CYCLES);
    // oe follows the synchronised level, so a glitch on the pin cannot chatter the pad
    assign oe_v[ch] = dis_lvl_q;

    dcs_clk_mux u_mux (
      .pclk(pclk),
      .presetn(presetn),
      .syn_clk(syn_q),
      .ref_clk(ref_lvl_q),
      .sel_syn(sel_lvl_q),
      .clk_out(mux_out_v[ch]),
      .on_syn(on_syn_v[ch])
    );
  end

  // ==========================================================
  // channel A divided copies, registered with the full-rate copy
  logic a_q;
  logic half_q;
  logic quarter_q;
  logic b_q;
  logic ref_osc_buffered_out_q;
  wire a_rise = mux_out_v[0] && !a_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_q <= 1'b0;
      half_q <= 1'b0;
      quarter_q <= 1'b0;
      b_q <= 1'b0;
      ref_osc_buffered_out_q <= 1'b0;
    end
    else
    begin
      a_q <= mux_out_v[0];
      b_q <= mux_out_v[1];
      ref_osc_buffered_out_q <= ref_lvl_q;
      if (a_rise)
        half_q <= !half_q;
      if (a_rise && half_q)
        quarter_q <= !quarter_q;
    end
  end

  assign chan_a_clk_out = a_q;
  assign chan_a_clk_half = half_q;
  assign chan_a_clk_quarter = quarter_q;
  assign chan_b_clk_out = b_q;
  assign ref_osc_buffered_out = ref_osc_buffered_out_q;
  assign chan_a_clk_out_oe = oe_v[0];
  assign chan_a_clk_half_oe = oe_v[0];
  assign chan_a_clk_quarter_oe = oe_v[0];
  assign chan_b_clk_out_oe = oe_v[1];

endmodule

// >>> tb/dcs_ctrl_properties.sv
// assertion checker for the synthesiser control block ports
`timescale 1ns/1ps
// ====
// port properties
module dcs_ctrl_chk
  import dcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chan_a_ref_bypass_sel,
  input wire logic chan_b_ref_bypass_sel,
  input wire logic chan_a_output_disable_n,
  input wire logic chan_b_output_disable_n,
  input wire logic chan_a_clk_out,
  input wire logic chan_a_clk_out_oe,
  input wire logic chan_a_clk_half,
  input wire logic chan_a_clk_half_oe,
  input wire logic chan_a_clk_quarter,
  input wire logic chan_a_clk_quarter_oe,
  input wire logic chan_b_clk_out,
  input wire logic chan_b_clk_out_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic unmapped = !(paddr inside {CTRL_OFFS, STAT_OFFS, WORD_A_OFFS, WORD_B_OFFS});
  // 16 cycles covers sync, wait for both clocks low and output lag
  sequence s_a_byp;
    !chan_a_ref_bypass_sel [*8] ##1 !chan_a_ref_bypass_sel [*8];
  endsequence
  sequence s_b_byp;
    !chan_b_ref_bypass_sel [*8] ##1 !chan_b_ref_bypass_sel [*8];
  endsequence
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_decode: assert property (psel && penable |-> pslverr == unmapped)
    else $error("pslverr does not match address decode");
  a_oe_off_a: assert property ($fell(chan_a_output_disable_n) |-> ##[1:8] !chan_a_clk_out_oe)
    else $error("channel a output not released");
  a_oe_off_b: assert property (!chan_b_output_disable_n [*8] |-> !chan_b_clk_out_oe)
    else $error("channel b output not released");
  a_oe_pull_up: assert property (chan_a_output_disable_n [*8] |->
    chan_a_clk_out_oe && chan_a_clk_half_oe && chan_a_clk_quarter_oe)
    else $error("channel a outputs not driven");
  a_half_rate: assert property ($rose(chan_a_clk_out) |-> $changed(chan_a_clk_half))
    else $error("half rate output missed an edge");
  a_half_only: assert property ($changed(chan_a_clk_half) |-> $rose(chan_a_clk_out))
    else $error("half rate output moved off edge");
  a_quarter_rate: assert property ($changed(chan_a_clk_quarter) |->
    $rose(chan_a_clk_out) && $changed(chan_a_clk_half))
    else $error("quarter rate output misaligned");
  a_ref_pulse_a: assert property (s_a_byp ##0 $rose(chan_a_clk_out) |-> chan_a_clk_out [*2])
    else $error("short pulse on channel a");
  a_ref_pulse_b: assert property (s_b_byp ##0 $rose(chan_b_clk_out) |-> chan_b_clk_out [*2])
    else $error("short pulse on channel b");
endmodule

// >>> tb/dcs_host.sv
// host model driving serial programming and bypass select lines
`timescale 1ns/1ps
// ====
// host side of the programming link
module dcs_host
  import dcs_pkg::*;
#(
  parameter int HOLD = 8
)
(
  input wire logic pclk,
  output logic serial_data,
  output logic sclk_a,
  output logic sclk_b,
  output logic sel_a,
  output logic sel_b
);
  initial
  begin
    serial_data = 1'b0;
    sclk_a = 1'b0;
    sclk_b = 1'b0;
    sel_a = 1'b1;
    sel_b = 1'b1;
  end
  // bypass before shifting, raise only after settling
  task automatic set_sel(input logic ch, input logic v);
    @(posedge pclk);
    if (ch)
      sel_b <= v;
    else
      sel_a <= v;
  endtask
  // lsb first; the first two bits fall out of the 22-bit word
  task automatic shift(input logic ch, input logic [WORD_W+1:0] w);
    for (int i = 0; i < WORD_W + 2; i++)
    begin
      @(posedge pclk);
      serial_data <= w[i];
      repeat (HOLD) @(posedge pclk);
      if (ch)
        sclk_b <= 1'b1;
      else
        sclk_a <= 1'b1;
      repeat (HOLD) @(posedge pclk);
      sclk_a <= 1'b0;
      sclk_b <= 1'b0;
    end
    // released data line shows the inverse, never a stale bit
    @(posedge pclk);
    serial_data <= ~w[WORD_W+1];
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking testbench for the synthesiser control block
`timescale 1ns/1ps
// ====
// bench top
module testbench import dcs_pkg::*;;
  localparam int WIN = 1280;
  localparam logic [21:0] WA = {4'h5, 7'h01, 1'b1, 3'h2, 7'h02};
  localparam logic [21:0] WB = {4'h3, 7'h01, 1'b1, 3'h0, 7'h02};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ref_clk = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sdata, sclk_a, sclk_b, sel_a, sel_b;
  logic ca, ca_oe, ch, ch_oe, cq, cq_oe, cb, cb_oe, xb;
  logic dis_a = 1'b1;
  logic dis_b = 1'b1;
  tri1 dis_a_w;
  tri1 dis_b_w;
  int errors = 0;
  int n_checks = 0;
  // released disable pins float up to the pull-up level
  assign dis_a_w = dis_a ? 1'bz : 1'b0;
  assign dis_b_w = dis_b ? 1'bz : 1'b0;
  always #5 pclk = ~pclk;
  // reference at pclk/8, well under the pclk/4 limit of the input sync
  always #40 ref_clk = ~ref_clk;
  dcs_ctrl #(.SETTLE_CYCLES(200)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk), .serial_data(sdata),
    .chan_a_serial_clk(sclk_a), .chan_b_serial_clk(sclk_b), .chan_a_ref_bypass_sel(sel_a),
    .chan_b_ref_bypass_sel(sel_b), .chan_a_output_disable_n(dis_a_w),
    .chan_b_output_disable_n(dis_b_w), .chan_a_clk_out(ca), .chan_a_clk_out_oe(ca_oe),
    .chan_a_clk_half(ch), .chan_a_clk_half_oe(ch_oe), .chan_a_clk_quarter(cq),
    .chan_a_clk_quarter_oe(cq_oe), .chan_b_clk_out(cb), .chan_b_clk_out_oe(cb_oe),
    .ref_osc_buffered_out(xb));
  dcs_host host (.pclk(pclk), .serial_data(sdata), .sclk_a(sclk_a), .sclk_b(sclk_b),
    .sel_a(sel_a), .sel_b(sel_b));
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
    input string what);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(what, d & m, exp);
  endtask
  // 0 channel a, 1 channel b, 2 reference buffer, 3 channel a half rate
  function automatic logic pick(input logic [1:0] s);
    pick = s == 2'h3 ? ch : s == 2'h2 ? xb : s == 2'h1 ? cb : ca;
  endfunction
  // window of whole budget periods, so bursty synthesis still averages out
  task automatic rate(input logic [1:0] b, input int exp, input string what);
    int n;
    logic p;
    n = 0;
    p = pick(b);
    repeat (WIN)
    begin
      @(posedge pclk);
      if (pick(b) && !p)
        n++;
      p = pick(b);
    end
    chk(what, 32'(n >= exp - exp / 20 - 2 && n <= exp + exp / 20 + 2), 32'h1);
    $display("rate %s edges %0d", what, n);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    rchk(CTRL_OFFS, 32'hFFFFFFFF, {16'h0, QUIET_RST}, "ctrl reset");
    rchk(WORD_B_OFFS, 32'hFFFFFFFF, {10'h0, WORD_RST}, "word b reset");
    rchk(STAT_OFFS, 32'h33, 32'h3, "stat reset");
    apb(1'b0, 12'h010, 32'h0, d, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", d, 32'h0);
    apb(1'b1, WORD_A_OFFS, 32'h3FFFFF, d, e);
    rchk(WORD_A_OFFS, 32'hFFFFFFFF, {10'h0, WORD_RST}, "word a read only");
    apb(1'b1, CTRL_OFFS, 32'h14, d, e);
    rchk(CTRL_OFFS, 32'hFFFFFFFF, 32'h14, "ctrl write");
    $display("test regs done");
  endtask
  task automatic t_retune();
    host.set_sel(1'b0, 1'b0);
    host.set_sel(1'b1, 1'b0);
    host.shift(1'b0, {WA, 2'b10});
    repeat (40) @(posedge pclk);
    rchk(WORD_A_OFFS, 32'hFFFFFFFF, {10'h0, WA}, "word a");
    rchk(STAT_OFFS, 32'h1, 32'h0, "a settling");
    host.shift(1'b1, {WB, 2'b01});
    repeat (40) @(posedge pclk);
    rchk(WORD_B_OFFS, 32'hFFFFFFFF, {10'h0, WB}, "word b");
    rchk(STAT_OFFS, 32'h3, 32'h1, "a settled b settling");
    rate(1'b1, WIN / 8, "b ref while retuning");
    rate(1'b0, WIN / 8, "a ref");
    rate(2'h2, WIN / 8, "ref buffer");
    rchk(STAT_OFFS, 32'hF, 32'h3, "settled on ref");
    host.set_sel(1'b0, 1'b1);
    host.set_sel(1'b1, 1'b1);
    repeat (40) @(posedge pclk);
    rchk(STAT_OFFS, 32'hF, 32'hF, "on synth");
    // two times ref_clk_in times p over q, over two to the m; ref_clk_in is pclk/8
    rate(1'b0, WIN * 2 * 4 / 4 / 4 / 8, "a synth");
    rate(2'h3, WIN * 2 * 4 / 4 / 4 / 8 / 2, "a half synth");
    rate(1'b1, WIN * 2 * 4 / 4 / 1 / 8, "b synth");
    $display("test retune done");
  endtask
  task automatic t_disable();
    @(posedge pclk);
    dis_a <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("a disabled oe", {28'h0, ca_oe, ch_oe, cq_oe, cb_oe}, 32'h1);
    dis_a <= 1'b1;
    dis_b <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("b disabled oe", {28'h0, ca_oe, ch_oe, cq_oe, cb_oe}, 32'hE);
    dis_b <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("released oe", {28'h0, ca_oe, ch_oe, cq_oe, cb_oe}, 32'hF);
    $display("test disable done");
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_retune();
    t_disable();
    close_out();
  end
endmodule
bind dcs_ctrl dcs_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .chan_a_ref_bypass_sel(chan_a_ref_bypass_sel), .chan_b_ref_bypass_sel(chan_b_ref_bypass_sel),
  .chan_a_output_disable_n(chan_a_output_disable_n),
  .chan_b_output_disable_n(chan_b_output_disable_n), .chan_a_clk_out(chan_a_clk_out),
  .chan_a_clk_out_oe(chan_a_clk_out_oe), .chan_a_clk_half(chan_a_clk_half),
  .chan_a_clk_half_oe(chan_a_clk_half_oe), .chan_a_clk_quarter(chan_a_clk_quarter),
  .chan_a_clk_quarter_oe(chan_a_clk_quarter_oe), .chan_b_clk_out(chan_b_clk_out),
  .chan_b_clk_out_oe(chan_b_clk_out_oe));
